// ### block_ram_read_during_write_tb.sv
// Purpose: Self-checking bench of the block RAM read-during-write choices.
// Assumes: Zero-wait APB slave; bypassed output shows a read one cycle later.
// Notes: A reference array in the bench predicts every read word.
`timescale 1ns/1ps
`include "brrdw_consts.svh"
module block_ram_read_during_write_tb;
    import brrdw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, a_q, b_q, a_wdata, b_wdata, rd;
    logic [3:0] pstrb = 4'hf, a_be, b_be;
    logic a_we, a_re, a_in_ce, a_out_ce, b_we, b_re, b_in_ce, b_out_ce;
    logic [7:0] a_addr, b_addr;
    logic [45:0] qa = 46'h0, qb = 46'h0;
    logic [31:0] mem [256];
    int n_mismatch = 0, samples_checked = 0, seed = 32'hb278;
    bit sn_a, sn_b, md_a, md_b, clk_new, oreg_a, oreg_b;
    always #25 pclk = ~pclk;
    brrdw_ram #(.IMAGE_MODE(BRRDW_IMG_UNCOMP_INIT), .INIT_IMAGE('{default: 32'h5a5a_0000}))
    dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .a_addr(a_addr), .a_wdata(a_wdata), .a_be(a_be), .a_we(a_we),
        .a_re(a_re), .a_in_ce(a_in_ce), .a_out_ce(a_out_ce), .a_q(a_q), .b_addr(b_addr),
        .b_wdata(b_wdata), .b_be(b_be), .b_we(b_we), .b_re(b_re), .b_in_ce(b_in_ce),
        .b_out_ce(b_out_ce), .b_q(b_q));
    brrdw_user ua (.req(qa), .addr(a_addr), .wdata(a_wdata), .be(a_be), .we(a_we),
        .re(a_re), .in_ce(a_in_ce), .out_ce(a_out_ce));
    brrdw_user ub (.req(qb), .addr(b_addr), .wdata(b_wdata), .be(b_be), .we(b_we),
        .re(b_re), .in_ce(b_in_ce), .out_ce(b_out_ce));
    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            if (m[i]) o[8*i +: 8] = n[8*i +: 8];
        end
        return o;
    endfunction
    function automatic logic [31:0] rexp(logic [45:0] r, logic [45:0] t, bit sn, bit md);
        logic [31:0] o;
        o = mem[r[39:32]];
        if (t[44] && t[39:32] == r[39:32]) begin
            if (clk_new) return mrg(o, t[31:0], t[43:40]);
            return md ? 32'hffff_ffff : o;
        end
        if (r[44] && sn) return mrg(o, r[31:0], r[43:40]);
        return o;
    endfunction
    function automatic logic [45:0] rq(bit r, bit w, logic [3:0] b, logic [7:0] a);
        return {r, w, b, a, $random(seed)};
    endfunction
    function automatic logic [45:0] rnd();
        logic [63:0] v;
        v = {$random(seed), $random(seed)};
        v[39:34] = 6'h00;
        return v[45:0];
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(logic [31:0] v);
        apb(1'b1, `BRRDW_OFS_CTRL, v);
        sn_a = (v[5:4] == 2'b01);
        sn_b = (v[9:8] == 2'b01);
        md_a = v[6];
        md_b = v[10];
        clk_new = v[3];
        oreg_a = v[12];
        oreg_b = v[13];
    endtask
    task automatic op(logic [45:0] ra, logic [45:0] rb);
        logic [31:0] ea, eb;
        if (ra[44] && rb[44] && ra[39:32] == rb[39:32]) rb[44] = 1'b0;
        ea = rexp(ra, rb, sn_a, md_a);
        eb = rexp(rb, ra, sn_b, md_b);
        @(posedge pclk);
        qa <= ra;
        qb <= rb;
        @(posedge pclk);
        qa <= 46'h0;
        qb <= 46'h0;
        if (ra[44]) mem[ra[39:32]] = mrg(mem[ra[39:32]], ra[31:0], ra[43:40]);
        if (rb[44]) mem[rb[39:32]] = mrg(mem[rb[39:32]], rb[31:0], rb[43:40]);
        #1;
        if (ra[45] && !oreg_a) chk("a_q", ea, a_q);
        if (rb[45] && !oreg_b) chk("b_q", eb, b_q);
        if (oreg_a || oreg_b) begin
            @(posedge pclk);
            #1;
            if (ra[45] && oreg_a) chk("a_q", ea, a_q);
            if (rb[45] && oreg_b) chk("b_q", eb, b_q);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h5a5a_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("a_q", 32'h0, a_q);
        chk("b_q", 32'h0, b_q);
        apb(1'b0, `BRRDW_OFS_CTRL, 32'h0);
        chk("ctrl", `BRRDW_CTRL_RST, rd);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        cfg(32'h0000_0333);
        op(rq(1, 0, 4'h0, 8'h05), rq(1, 0, 4'h0, 8'h06));
        cfg(32'h0000_0010);
        op(rq(1, 1, 4'h5, 8'h03), 46'h0);
        cfg(32'h0000_0000);
        op(rq(1, 1, 4'hf, 8'h03), 46'h0);
        cfg(32'h0000_0001);
        op(rq(0, 1, 4'hf, 8'h07), rq(1, 0, 4'h0, 8'h07));
        apb(1'b0, `BRRDW_OFS_STAT, 32'h0);
        chk("status", 32'h6, rd);
        apb(1'b1, `BRRDW_OFS_STAT, 32'h7);
        apb(1'b0, `BRRDW_OFS_STAT, 32'h0);
        chk("status", 32'h0, rd);
        cfg(32'h0000_0401);
        op(rq(0, 1, 4'h9, 8'h07), rq(1, 0, 4'h0, 8'h07));
        cfg(32'h0000_000d);
        op(rq(0, 1, 4'h6, 8'h07), rq(1, 0, 4'h0, 8'h07));
        apb(1'b0, `BRRDW_OFS_STAT, 32'h0);
        chk("status", 32'hc, rd);
        cfg(32'h0000_0113);
        repeat (60) op(rnd(), rnd());
        // Deliberate clash to see the unarbitrated result; real user logic must avoid it.
        @(posedge pclk);
        qa <= rq(0, 1, 4'hf, 8'h09);
        qb <= rq(0, 1, 4'hf, 8'h09);
        @(posedge pclk);
        qa <= 46'h0;
        qb <= 46'h0;
        mem[9] = 32'hffff_ffff;
        op(rq(1, 0, 4'h0, 8'h09), 46'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk("a_q", 32'h0, a_q);
        chk("b_q", 32'h0, b_q);
        presetn <= 1'b1;
        cfg(32'h0000_3333);
        op(rq(1, 0, 4'h0, 8'h07), rq(1, 0, 4'h0, 8'h06));
        close_out();
    end
endmodule

// ### brrdw_apb.sv
// Purpose: APB slave holding the mode control word and the sticky status bits.
// Assumes: Zero-wait APB; read data is captured in the setup cycle.
// Notes: A hardware set in the cycle of a write-one-to-clear keeps the bit set.
`timescale 1ns/1ps
`include "brrdw_consts.svh"
module brrdw_apb
    import brrdw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BRRDW_PAW-1:0] paddr,
    input wire logic [`BRRDW_DW-1:0] pwdata,
    input wire logic [`BRRDW_NBYTE-1:0] pstrb,
    output logic [`BRRDW_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`BRRDW_DW-1:0] ctrl,
    input wire logic set_coll,
    input wire logic set_same,
    input wire logic set_mix,
    input wire logic cfg_err
);
    brrdw_apb_st_t st_ff;
    brrdw_apb_st_t nxt_st;
    logic mapped;

    assign mapped = (paddr == `BRRDW_OFS_CTRL) || (paddr == `BRRDW_OFS_STAT);

    always_comb begin
        nxt_st = st_ff;
        if (psel && penable && pwrite && (paddr == `BRRDW_OFS_CTRL)) begin
            for (int i = 0; i < `BRRDW_NBYTE; i++) begin
                if (pstrb[i]) begin
                    nxt_st.ctrl[8*i +: 8] = pwdata[8*i +: 8];
                end
            end
            nxt_st.ctrl = nxt_st.ctrl & `BRRDW_CTRL_MASK;
        end
        if (psel && penable && pwrite && (paddr == `BRRDW_OFS_STAT) && pstrb[0]) begin
            nxt_st.sticky = st_ff.sticky & ~pwdata[2:0];
        end
        nxt_st.sticky[`BRRDW_STAT_COLL_BIT] = nxt_st.sticky[`BRRDW_STAT_COLL_BIT] | set_coll;
        nxt_st.sticky[`BRRDW_STAT_SAME_BIT] = nxt_st.sticky[`BRRDW_STAT_SAME_BIT] | set_same;
        nxt_st.sticky[`BRRDW_STAT_MIX_BIT] = nxt_st.sticky[`BRRDW_STAT_MIX_BIT] | set_mix;
        if (psel && !penable && !pwrite) begin
            if (paddr == `BRRDW_OFS_CTRL) begin
                nxt_st.rdata = st_ff.ctrl;
            end else if (paddr == `BRRDW_OFS_STAT) begin
                nxt_st.rdata = {28'h0000000, cfg_err, st_ff.sticky};
            end else begin
                nxt_st.rdata = `BRRDW_ZERO_WORD;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{ctrl: `BRRDW_CTRL_RST, sticky: `BRRDW_STICKY_RST, rdata: `BRRDW_ZERO_WORD};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ctrl = st_ff.ctrl;
    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule

// ### brrdw_consts.svh
// Purpose: Shared constants of the block RAM with read-during-write control.
// Assumes: Included by the package and by every design file that needs a figure.
// Notes: Register offsets are byte addresses on a 32-bit APB data path.
`ifndef BRRDW_CONSTS_SVH
`define BRRDW_CONSTS_SVH
`define BRRDW_DW 32
`define BRRDW_AW 8
`define BRRDW_WORDS 256
`define BRRDW_NBYTE 4
`define BRRDW_PAW 12
`define BRRDW_OFS_CTRL 12'h000
`define BRRDW_OFS_STAT 12'h004
`define BRRDW_CTRL_MEM_LSB 0
`define BRRDW_CTRL_CLK_LSB 2
`define BRRDW_CTRL_ASAME_LSB 4
`define BRRDW_CTRL_AMIX_BIT 6
`define BRRDW_CTRL_BSAME_LSB 8
`define BRRDW_CTRL_BMIX_BIT 10
`define BRRDW_CTRL_AOREG_BIT 12
`define BRRDW_CTRL_BOREG_BIT 13
`define BRRDW_CTRL_MASK 32'h0000_377f
`define BRRDW_CTRL_RST 32'h0000_0333
`define BRRDW_STAT_COLL_BIT 0
`define BRRDW_STAT_SAME_BIT 1
`define BRRDW_STAT_MIX_BIT 2
`define BRRDW_STAT_CFGERR_BIT 3
`define BRRDW_STICKY_RST 3'h0
`define BRRDW_DC_WORD 32'hffff_ffff
`define BRRDW_ZERO_WORD 32'h0000_0000
`endif

// ### brrdw_pkg.sv
// Purpose: Types and the shared byte-merge function of the block RAM.
// Assumes: brrdw_consts.svh supplies every width.
// Notes: Mode encodings step by one bit along the usual order.
package brrdw_pkg;
`include "brrdw_consts.svh"

    typedef enum logic [1:0] {
        BRRDW_SP = 2'b00,
        BRRDW_SDP = 2'b01,
        BRRDW_TDP = 2'b11
    } brrdw_mem_mode_t;

    typedef enum logic [1:0] {
        BRRDW_CLK_SINGLE = 2'b00,
        BRRDW_CLK_INOUT = 2'b01,
        BRRDW_CLK_RDWR = 2'b11,
        BRRDW_CLK_INDEP = 2'b10
    } brrdw_clk_mode_t;

    typedef enum logic [1:0] {
        BRRDW_SAME_DC = 2'b00,
        BRRDW_SAME_NEW = 2'b01,
        BRRDW_SAME_OLD = 2'b11
    } brrdw_same_mode_t;

    typedef enum logic [2:0] {
        BRRDW_IMG_DUAL = 3'b000,
        BRRDW_IMG_COMP = 3'b001,
        BRRDW_IMG_UNCOMP = 3'b011,
        BRRDW_IMG_COMP_INIT = 3'b010,
        BRRDW_IMG_UNCOMP_INIT = 3'b110
    } brrdw_image_t;

    typedef struct packed {
        logic [`BRRDW_DW-1:0] ctrl;
        logic [2:0] sticky;
        logic [`BRRDW_DW-1:0] rdata;
    } brrdw_apb_st_t;

    typedef struct packed {
        logic [`BRRDW_DW-1:0] latch;
        logic [`BRRDW_DW-1:0] oreg;
        logic seen;
    } brrdw_port_st_t;

    function automatic logic [`BRRDW_DW-1:0] brrdw_merge(
        input logic [`BRRDW_DW-1:0] old_w,
        input logic [`BRRDW_DW-1:0] new_w,
        input logic [`BRRDW_NBYTE-1:0] be);
        logic [`BRRDW_DW-1:0] res;
        res = old_w;
        for (int i = 0; i < `BRRDW_NBYTE; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction
endpackage

// ### brrdw_port.sv
// Purpose: Read path of one RAM port: read-during-write choice, output latch, output register.
// Assumes: Hit flags and the old word arrive from the array on the same clock.
// Notes: Only the latch, the output register and the seen flag are cleared by the asynchronous reset.
`timescale 1ns/1ps
`include "brrdw_consts.svh"
module brrdw_port
    import brrdw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rd_take,
    input wire logic out_ce,
    input wire logic out_reg_en,
    input wire logic [`BRRDW_DW-1:0] old_word,
    input wire logic [`BRRDW_DW-1:0] own_wdata,
    input wire logic [`BRRDW_NBYTE-1:0] own_be,
    input wire logic [`BRRDW_DW-1:0] oth_wdata,
    input wire logic [`BRRDW_NBYTE-1:0] oth_be,
    input wire logic same_hit,
    input wire logic mixed_hit,
    input wire logic same_new,
    input wire logic mixed_dc,
    input wire logic clk_shared,
    output logic [`BRRDW_DW-1:0] q
);
    brrdw_port_st_t st_ff;
    brrdw_port_st_t nxt_st;
    logic [`BRRDW_DW-1:0] rd_val;

    always_comb begin
        nxt_st = st_ff;
        rd_val = old_word;
        if (same_hit && mixed_hit) begin
            rd_val = `BRRDW_DC_WORD;
        end else if (same_hit) begin
            // Masked bytes keep the old contents because they are not stored.
            rd_val = same_new ? brrdw_merge(old_word, own_wdata, own_be) : old_word;
        end else if (mixed_hit) begin
            if (!clk_shared) begin
                // Unrelated clocks let the write win; software must not rely on it.
                rd_val = brrdw_merge(old_word, oth_wdata, oth_be);
            end else if (mixed_dc) begin
                rd_val = `BRRDW_DC_WORD;
            end else begin
                rd_val = old_word;
            end
        end
        if (rd_take) begin
            nxt_st.latch = rd_val;
            nxt_st.seen = 1'b1;
        end
        if (out_ce) begin
            nxt_st.oreg = st_ff.latch;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{latch: `BRRDW_ZERO_WORD, oreg: `BRRDW_ZERO_WORD, seen: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = out_reg_en ? st_ff.oreg : st_ff.latch;

    a_same_new: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_take && same_hit && !mixed_hit && same_new)
        |=> st_ff.latch == brrdw_merge($past(old_word), $past(own_wdata), $past(own_be)))
        else $error("same-port new data not merged into the latch");
    a_same_old: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_take && same_hit && !mixed_hit && !same_new) |=> st_ff.latch == $past(old_word))
        else $error("same-port old data not returned");
    a_mixed_old: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_take && mixed_hit && !same_hit && clk_shared && !mixed_dc)
        |=> st_ff.latch == $past(old_word))
        else $error("mixed-port old data not returned");
    a_mixed_dc: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_take && mixed_hit && !same_hit && clk_shared && mixed_dc)
        |=> st_ff.latch == `BRRDW_DC_WORD)
        else $error("mixed-port don't-care word not returned");
    a_diff_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_take && mixed_hit && !same_hit && !clk_shared)
        |=> st_ff.latch == brrdw_merge($past(old_word), $past(oth_wdata), $past(oth_be)))
        else $error("unrelated-clock read did not return the written word");
    a_pwr_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !st_ff.seen |-> q == `BRRDW_ZERO_WORD)
        else $error("output not zero before the first read");
    a_outce_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !out_ce |=> $stable(st_ff.oreg))
        else $error("output register moved while its enable was low");
    a_rd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!rd_take ##1 !rd_take) |=> $stable(st_ff.latch))
        else $error("read latch moved without a read");
endmodule

// ### brrdw_ram.sv
// Purpose: 256 x 32 block RAM with selectable port mode and read-during-write choice.
// Assumes: Both ports and the APB run on pclk; user inputs come from logic on that clock.
// Notes: The clock-mode field selects the mixed-port read-during-write answer and feeds the legality check; there is one clock.
`timescale 1ns/1ps
`include "brrdw_consts.svh"
// Contract
// - Two true dual-port writes to one address leave that word unknown.
// - Same-port case is one port reading and writing its own address.
// - Same-port new-data mode shows the written word on the same edge.
// - With byte masks, enabled bytes show new data, masked bytes old data.
// - Same-port don't-care mode shows the contents before the write.
// - Mixed-port case is one port reading what the other port writes.
// - Mixed-port old-data mode returns the contents before the write.
// - Mixed-port don't-care mode returns an unspecified word.
// - A shared clock on both ports returns old contents on mixed hits in old-data mode.
// - Different clocks make a mixed hit return old or new data.
// - Read output is zero at power-up, registered or not.
// - Initial contents appear only from the first read after power-up.
// - Without an initial image every cell starts at zero.
// - Initial contents load only in image modes that include memory init.
// - Input and output registers have their own clock enables.
// - Single-port RAM allows only same-port cases, single or in/out clock.
// - Simple dual-port allows only mixed-port cases, single or in/out clock.
// - True dual-port same-port case allows single, in/out or independent clock.
// - True dual-port mixed-port case allows only single or in/out clock.
// - Only the listed output choices per memory mode are legal.
// - Asynchronous clear touches only output latches and output registers; here presetn also resets the APB control and status registers.
module brrdw_ram
    import brrdw_pkg::*;
#(
    parameter brrdw_image_t IMAGE_MODE = BRRDW_IMG_COMP_INIT,
    parameter logic [`BRRDW_DW-1:0] INIT_IMAGE [`BRRDW_WORDS] = '{default: 32'h0000_0000}
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BRRDW_PAW-1:0] paddr,
    input wire logic [`BRRDW_DW-1:0] pwdata,
    input wire logic [`BRRDW_NBYTE-1:0] pstrb,
    output logic [`BRRDW_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`BRRDW_AW-1:0] a_addr,
    input wire logic [`BRRDW_DW-1:0] a_wdata,
    input wire logic [`BRRDW_NBYTE-1:0] a_be,
    input wire logic a_we,
    input wire logic a_re,
    input wire logic a_in_ce,
    input wire logic a_out_ce,
    output logic [`BRRDW_DW-1:0] a_q,
    input wire logic [`BRRDW_AW-1:0] b_addr,
    input wire logic [`BRRDW_DW-1:0] b_wdata,
    input wire logic [`BRRDW_NBYTE-1:0] b_be,
    input wire logic b_we,
    input wire logic b_re,
    input wire logic b_in_ce,
    input wire logic b_out_ce,
    output logic [`BRRDW_DW-1:0] b_q
);
    // Memory init only exists in the single-image modes that carry it.
    function automatic logic image_has_init(input brrdw_image_t img);
        return (img == BRRDW_IMG_COMP_INIT) || (img == BRRDW_IMG_UNCOMP_INIT);
    endfunction

    // A shared clock source is what makes mixed-port reads return old data.
    function automatic logic clock_shared(input brrdw_clk_mode_t cm);
        return (cm == BRRDW_CLK_SINGLE) || (cm == BRRDW_CLK_INOUT);
    endfunction

    localparam logic [`BRRDW_DW-1:0] ZERO_IMAGE [`BRRDW_WORDS] = '{default: 32'h0000_0000};
    localparam logic [`BRRDW_DW-1:0] START_IMAGE [`BRRDW_WORDS] =
        image_has_init(IMAGE_MODE) ? INIT_IMAGE : ZERO_IMAGE;

    // The array has no reset on purpose: clearing it would destroy the initial image.
    logic [`BRRDW_DW-1:0] mem_ff [`BRRDW_WORDS] = START_IMAGE;

    logic [`BRRDW_DW-1:0] ctrl;
    brrdw_mem_mode_t mem_mode;
    brrdw_clk_mode_t clk_mode;
    brrdw_same_mode_t a_same_mode;
    brrdw_same_mode_t b_same_mode;
    logic a_mix_dc;
    logic b_mix_dc;
    logic a_oreg_en;
    logic b_oreg_en;
    logic shared_clk;
    logic wa;
    logic wb;
    logic ra;
    logic rb;
    logic addr_eq;
    logic coll;
    logic a_same_hit;
    logic b_same_hit;
    logic a_mixed_hit;
    logic b_mixed_hit;
    logic cfg_legal;
    logic [`BRRDW_DW-1:0] a_old;
    logic [`BRRDW_DW-1:0] b_old;

    brrdw_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl(ctrl),
        .set_coll(coll),
        .set_same(a_same_hit || b_same_hit),
        .set_mix(a_mixed_hit || b_mixed_hit),
        .cfg_err(!cfg_legal)
    );

    assign mem_mode = brrdw_mem_mode_t'(ctrl[`BRRDW_CTRL_MEM_LSB +: 2]);
    assign clk_mode = brrdw_clk_mode_t'(ctrl[`BRRDW_CTRL_CLK_LSB +: 2]);
    assign a_same_mode = brrdw_same_mode_t'(ctrl[`BRRDW_CTRL_ASAME_LSB +: 2]);
    assign b_same_mode = brrdw_same_mode_t'(ctrl[`BRRDW_CTRL_BSAME_LSB +: 2]);
    assign a_mix_dc = ctrl[`BRRDW_CTRL_AMIX_BIT];
    assign b_mix_dc = ctrl[`BRRDW_CTRL_BMIX_BIT];
    assign a_oreg_en = ctrl[`BRRDW_CTRL_AOREG_BIT];
    assign b_oreg_en = ctrl[`BRRDW_CTRL_BOREG_BIT];
    assign shared_clk = clock_shared(clk_mode);

    // Port roles per memory mode: single-port uses A only, simple dual-port
    // writes on A and reads on B, true dual-port lets both do both.
    always_comb begin
        wa = 1'b0;
        wb = 1'b0;
        ra = 1'b0;
        rb = 1'b0;
        unique case (mem_mode)
            BRRDW_SP: begin
                wa = a_we && a_in_ce;
                ra = a_re && a_in_ce;
            end
            BRRDW_SDP: begin
                wa = a_we && a_in_ce;
                rb = b_re && b_in_ce;
            end
            BRRDW_TDP: begin
                wa = a_we && a_in_ce;
                ra = a_re && a_in_ce;
                wb = b_we && b_in_ce;
                rb = b_re && b_in_ce;
            end
            default: begin
                wa = 1'b0;
                wb = 1'b0;
                ra = 1'b0;
                rb = 1'b0;
            end
        endcase
    end

    assign addr_eq = (a_addr == b_addr);
    assign coll = wa && wb && addr_eq;
    assign a_same_hit = ra && wa;
    assign b_same_hit = rb && wb;
    assign a_mixed_hit = ra && wb && addr_eq;
    assign b_mixed_hit = rb && wa && addr_eq;

    // Static legality of the chosen output choices against memory and clock mode.
    always_comb begin
        cfg_legal = 1'b0;
        unique case (mem_mode)
            BRRDW_SP: cfg_legal = shared_clk;
            BRRDW_SDP: cfg_legal = shared_clk;
            BRRDW_TDP: begin
                // Independent clocks are legal for same-port use only.
                cfg_legal = (clk_mode != BRRDW_CLK_RDWR)
                    && (a_same_mode != BRRDW_SAME_DC) && (b_same_mode != BRRDW_SAME_DC);
            end
            default: cfg_legal = 1'b0;
        endcase
    end

    assign a_old = mem_ff[a_addr];
    assign b_old = mem_ff[b_addr];

    always_ff @(posedge pclk) begin
        if (coll) begin
            // No arbitration: the clashing word is stored as the don't-care word.
            mem_ff[a_addr] <= `BRRDW_DC_WORD;
        end else begin
            if (wa) begin
                mem_ff[a_addr] <= brrdw_merge(a_old, a_wdata, a_be);
            end
            if (wb) begin
                mem_ff[b_addr] <= brrdw_merge(b_old, b_wdata, b_be);
            end
        end
    end

    brrdw_port u_port_a (
        .pclk(pclk),
        .presetn(presetn),
        .rd_take(ra),
        .out_ce(a_out_ce),
        .out_reg_en(a_oreg_en),
        .old_word(a_old),
        .own_wdata(a_wdata),
        .own_be(a_be),
        .oth_wdata(b_wdata),
        .oth_be(b_be),
        .same_hit(a_same_hit),
        .mixed_hit(a_mixed_hit),
        .same_new(a_same_mode == BRRDW_SAME_NEW),
        .mixed_dc(a_mix_dc),
        .clk_shared(shared_clk),
        .q(a_q)
    );

    brrdw_port u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .rd_take(rb),
        .out_ce(b_out_ce),
        .out_reg_en(b_oreg_en),
        .old_word(b_old),
        .own_wdata(b_wdata),
        .own_be(b_be),
        .oth_wdata(a_wdata),
        .oth_be(a_be),
        .same_hit(b_same_hit),
        .mixed_hit(b_mixed_hit),
        .same_new(b_same_mode == BRRDW_SAME_NEW),
        .mixed_dc(b_mix_dc),
        .clk_shared(shared_clk),
        .q(b_q)
    );

    a_coll_unknown: assert property (@(posedge pclk) disable iff (!presetn)
        coll |=> mem_ff[$past(a_addr)] == `BRRDW_DC_WORD)
        else $error("colliding writes did not leave the don't-care word");
    a_write_merge: assert property (@(posedge pclk) disable iff (!presetn)
        (wa && !coll && !(wb && addr_eq))
        |=> mem_ff[$past(a_addr)] == brrdw_merge($past(a_old), $past(a_wdata), $past(a_be)))
        else $error("port A write did not store the merged word");
    a_sp_roles: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_mode == BRRDW_SP) |-> !(wb || rb || a_mixed_hit || b_mixed_hit))
        else $error("single-port mode used port B");
    a_sdp_roles: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_mode == BRRDW_SDP) |-> !(ra || wb || a_same_hit || b_same_hit))
        else $error("simple dual-port mode used a forbidden direction");
    a_cfg_legal: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_mode == BRRDW_TDP && a_same_mode == BRRDW_SAME_DC) |-> !cfg_legal)
        else $error("true dual-port don't-care same-port choice reported legal");
    a_mixed_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_mode == BRRDW_TDP && clk_mode == BRRDW_CLK_RDWR) |-> !cfg_legal)
        else $error("true dual-port read/write clock mode reported legal");
    a_same_indep: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_mode == BRRDW_TDP && clk_mode == BRRDW_CLK_INDEP
            && a_same_mode == BRRDW_SAME_OLD && b_same_mode == BRRDW_SAME_NEW) |-> cfg_legal)
        else $error("independent clocks refused for same-port use");
    a_noread_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!ra && !a_oreg_en) ##1 !a_oreg_en |-> $stable(a_q))
        else $error("port A output moved without a read");
endmodule

// ### brrdw_user.sv
// Purpose: User logic on one RAM port, turning a packed request into port strobes.
// Assumes: The request word changes only just after a rising edge of pclk.
// Notes: Request layout is read, write, byte enables, address, data.
`timescale 1ns/1ps
`include "brrdw_consts.svh"
module brrdw_user
    import brrdw_pkg::*;
(
    input wire logic [45:0] req,
    output logic [`BRRDW_AW-1:0] addr,
    output logic [`BRRDW_DW-1:0] wdata,
    output logic [`BRRDW_NBYTE-1:0] be,
    output logic we,
    output logic re,
    output logic in_ce,
    output logic out_ce
);
    // Read enable stays low unless a read is wanted, which saves dynamic power.
    assign re = req[45];
    assign we = req[44];
    assign in_ce = req[45] | req[44];
    // The output register is clocked only while the input side rests, saving power.
    assign out_ce = ~(req[45] | req[44]);
    assign be = req[43:40];
    assign addr = req[39:32];
    // Idle data lines carry the inverse so a stale word never looks live.
    assign wdata = req[44] ? req[31:0] : ~req[31:0];
endmodule
